// file: verilog/acr_pkg.sv
package acr_pkg;
  // -------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // -------------------------------------------------------------
  localparam logic [7:0] ADDR_ALT_UPPER = 8'h00; // alt_count_upper_byte
  localparam logic [7:0] ADDR_ALT_LOWER = 8'h04; // alt_count_lower_byte
  localparam logic [7:0] ADDR_MAIN_UPPER = 8'h08; // main_count_upper_byte
  localparam logic [7:0] ADDR_MAIN_LOWER = 8'h0c; // main_count_lower_byte
  localparam logic [7:0] ADDR_STATUS = 8'h10; // timer_status_location
  localparam logic [7:0] ADDR_CONTROL = 8'h14; // overflow interrupt enable
  // -------------------------------------------------------------
  // field layout and reset values
  // -------------------------------------------------------------
  localparam int OVF_BIT = 7; // overflow flag position in status
  localparam int OVF_IE_BIT = 5; // overflow enable position in control
  localparam logic [15:0] COUNT_RESET = 16'hfffc;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  // -------------------------------------------------------------
  // prescaler
  // -------------------------------------------------------------
  localparam int PRESCALE_DIV = 4; // bus cycles per count
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);
  localparam logic [1:0] PRESCALE_STEP = 2'h1;
endpackage : acr_pkg

// file: verilog/acr_timer.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// -------------------------------------------------------------
// usage notes
// -------------------------------------------------------------
// software reads the upper byte first, then the lower byte
// an interrupt between the two reads may split the pair on the
// main path; the alternate path is the safe choice for polling
// a half-finished sequence leaves the lower byte frozen: lower
// reads return the old value until that sequence is completed
// the bus answers with no wait states, so read side effects land
// on the single access edge of each read
// only the overflow enable bit is writable; every other write is
// dropped, with an error response only at an unmapped address
module acr_timer
  import acr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer state
  output logic [15:0] countValue,
  output logic counterOverflowFlag,
  output logic overflowIrq
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [1:0] prescale_q; // fixed divide-by-four
  logic [15:0] count_q; // free-running counter
  logic [7:0] altLatch_q; // alternate lower latch
  logic altFrozen_q; // alternate latch holding
  logic [7:0] mainLatch_q; // main lower latch
  logic mainFrozen_q; // main latch holding
  logic ovf_q; // overflow flag
  logic ovfArmed_q; // status read seen with flag set
  logic ovfIe_q; // overflow interrupt enable
  logic [31:0] prdata_q; // registered read data
  // the latches, their freeze bits, the arm bit, the overflow flag and the
  // registered read data are the only state that a read may change; the count never is

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  // every read strobe below is qualified by the access phase,
  // so a setup cycle never triggers a side effect
  wire logic access = psel && penable; // single-cycle access phase
  wire logic rdAcc = access && !pwrite;
  wire logic wrAcc = access && pwrite;
  wire logic rdAltUp = rdAcc && (paddr == ADDR_ALT_UPPER);
  wire logic rdAltLo = rdAcc && (paddr == ADDR_ALT_LOWER);
  wire logic rdMainUp = rdAcc && (paddr == ADDR_MAIN_UPPER);
  wire logic rdMainLo = rdAcc && (paddr == ADDR_MAIN_LOWER);
  wire logic rdStatus = rdAcc && (paddr == ADDR_STATUS);
  wire logic wrControl = wrAcc && (paddr == ADDR_CONTROL);
  wire logic mapped = (paddr == ADDR_ALT_UPPER) || (paddr == ADDR_ALT_LOWER)
    || (paddr == ADDR_MAIN_UPPER) || (paddr == ADDR_MAIN_LOWER)
    || (paddr == ADDR_STATUS) || (paddr == ADDR_CONTROL);
  // counter tick on last prescaler phase
  wire logic tick = (prescale_q == PRESCALE_LAST);
  wire logic wrapNow = tick && (&count_q);

  // lower byte seen through a latch: live while transparent
  function automatic logic [7:0] lower_view(input logic frozen,
      input logic [7:0] held, input logic [15:0] cnt);
    lower_view = frozen ? held : cnt[7:0];
  endfunction : lower_view

  wire logic [7:0] altLower = lower_view(altFrozen_q, altLatch_q, count_q);
  wire logic [7:0] mainLower = lower_view(mainFrozen_q, mainLatch_q, count_q);

  // read mux; unmapped reads return zero with an error
  // the same mux feeds the registered copy, so prdata keeps the
  // last read value between transfers
  logic [31:0] readMux;
  always_comb begin
    readMux = 32'h0000_0000;
    case (paddr)
      ADDR_ALT_UPPER: readMux[7:0] = count_q[15:8];
      ADDR_ALT_LOWER: readMux[7:0] = altLower;
      ADDR_MAIN_UPPER: readMux[7:0] = count_q[15:8];
      ADDR_MAIN_LOWER: readMux[7:0] = mainLower;
      ADDR_STATUS: readMux[OVF_BIT] = ovf_q;
      ADDR_CONTROL: readMux[OVF_IE_BIT] = ovfIe_q;
      default: readMux = 32'h0000_0000;
    endcase
  end

  // -------------------------------------------------------------
  // prescaler and counter; no bus access reaches them
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prescale_q <= 2'h0;
      count_q <= COUNT_RESET;
    end else begin
      // never touched by software: only device reset restarts the
      // phase, so reads cannot shift the moment the count steps
      prescale_q <= prescale_q + PRESCALE_STEP;
      if (tick) begin
        count_q <= count_q + COUNT_STEP;
      end
    end
  end

  // -------------------------------------------------------------
  // alternate latch: driven only by alternate reads
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      altFrozen_q <= 1'b0;
      altLatch_q <= 8'h00;
    end else if (rdAltLo) begin
      altFrozen_q <= 1'b0;
    end else if (rdAltUp && !altFrozen_q) begin
      // repeated upper reads keep the first snapshot
      // the snapshot is taken on the edge that serves the upper
      // read, so both bytes come from one count value unless the upper byte is read again first
      altFrozen_q <= 1'b1;
      altLatch_q <= count_q[7:0];
    end
    // writes never land here, so the latch ignores them
  end

  // -------------------------------------------------------------
  // main latch, separate so the two paths never interfere
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mainFrozen_q <= 1'b0;
      mainLatch_q <= 8'h00;
    end else if (rdMainLo) begin
      mainFrozen_q <= 1'b0;
    end else if (rdMainUp && !mainFrozen_q) begin
      // kept beside the alternate latch so both paths can run
      // side by side; the flag side effect lives below
      mainFrozen_q <= 1'b1;
      mainLatch_q <= count_q[7:0];
    end
  end

  // -------------------------------------------------------------
  // overflow flag; a wrap in the clearing cycle wins
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ovf_q <= 1'b0;
      ovfArmed_q <= 1'b0;
    end else begin
      if (wrapNow) begin
        ovf_q <= 1'b1;
      end else if (rdMainLo && ovfArmed_q) begin
        ovf_q <= 1'b0;
      end
      // arm on status read, disarm after the main lower read
      // any main lower read ends the sequence, cleared or not,
      // so a stale arm never lingers
      if (rdStatus && ovf_q) begin
        ovfArmed_q <= 1'b1;
      end else if (rdMainLo) begin
        ovfArmed_q <= 1'b0;
      end
      // alternate reads take no part here
    end
  end

  // -------------------------------------------------------------
  // control register and read data
  // -------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ovfIe_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      // the enable only gates the request and never moves the flag
      if (wrControl) begin
        ovfIe_q <= pwdata[OVF_IE_BIT];
      end
      if (rdAcc) begin
        prdata_q <= readMux;
      end
    end
  end

  // zero-wait answer: data sampled combinationally in the access phase
  assign pready = 1'b1;
  assign prdata = rdAcc ? readMux : prdata_q;
  assign pslverr = access && !mapped;
  assign countValue = count_q;
  assign counterOverflowFlag = ovf_q;
  // a plain level: clearing the flag drops the request
  assign overflowIrq = ovf_q && ovfIe_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  // all checks run on the bus clock and stand down in reset;
  // the reset checks have no disable so that they see the release
  a_reset_preset: assert property (@(posedge core_clk)
    $fell(reset) |-> count_q == COUNT_RESET)
    else $error("counter not preset after reset");

  a_count_rate: assert property (@(posedge core_clk) disable iff (reset)
    tick |=> !tick [*3] ##1 tick)
    else $error("counter tick not every four cycles");

  a_count_step: assert property (@(posedge core_clk) disable iff (reset)
    $past(tick) && !$past(reset) |-> count_q == $past(count_q) + COUNT_STEP)
    else $error("counter did not advance by one");

  a_freeze_hold: assert property (@(posedge core_clk) disable iff (reset)
    rdAltUp && !altFrozen_q |=> altFrozen_q && altLatch_q == $past(count_q[7:0]))
    else $error("alternate lower byte not frozen");

  a_release_lower: assert property (@(posedge core_clk) disable iff (reset)
    rdAltLo |=> !altFrozen_q ##0 altLower == count_q[7:0])
    else $error("alternate latch not released");

  a_alt_no_ovf: assert property (@(posedge core_clk) disable iff (reset)
    (rdAltUp || rdAltLo) && !wrapNow && !rdMainLo |=> ovf_q == $past(ovf_q))
    else $error("alternate read altered overflow flag");

  a_write_ignored: assert property (@(posedge core_clk) disable iff (reset)
    wrAcc && (paddr == ADDR_ALT_UPPER || paddr == ADDR_ALT_LOWER)
    |=> altFrozen_q == $past(altFrozen_q) && ovf_q == $past(ovf_q))
    else $error("write to alternate byte had an effect");

  a_paths_apart: assert property (@(posedge core_clk) disable iff (reset)
    rdAltUp && !rdMainLo && !rdMainUp |=> mainFrozen_q == $past(mainFrozen_q))
    else $error("alternate read touched main latch");

  a_ovf_clear: assert property (@(posedge core_clk) disable iff (reset)
    $fell(ovf_q) |-> $past(rdMainLo) && $past(ovfArmed_q))
    else $error("overflow cleared without proper sequence");

  a_upper_read: assert property (@(posedge core_clk) disable iff (reset)
    rdAltUp |-> prdata == {24'h000000, count_q[15:8]})
    else $error("upper byte read wrong");

  a_frozen_lower: assert property (@(posedge core_clk) disable iff (reset)
    rdAltLo && altFrozen_q |-> prdata == {24'h000000, altLatch_q})
    else $error("frozen lower byte not returned");

  a_snapshot_kept: assert property (@(posedge core_clk) disable iff (reset)
    rdAltUp && altFrozen_q |=> altFrozen_q && altLatch_q == $past(altLatch_q))
    else $error("repeated upper read took a new snapshot");

  a_lower_live: assert property (@(posedge core_clk) disable iff (reset)
    !altFrozen_q && rdAltLo |-> prdata == {24'h000000, count_q[7:0]})
    else $error("transparent lower byte not live");

  a_wrap_flag: assert property (@(posedge core_clk) disable iff (reset)
    wrapNow |=> ovf_q && !(|count_q))
    else $error("wrap did not reach zero with flag set");

  a_count_hold: assert property (@(posedge core_clk) disable iff (reset)
    !tick |=> count_q == $past(count_q))
    else $error("counter moved without a tick");

  a_write_latch: assert property (@(posedge core_clk) disable iff (reset)
    wrAcc && (paddr == ADDR_ALT_UPPER || paddr == ADDR_ALT_LOWER)
    |=> altLatch_q == $past(altLatch_q) && ovfArmed_q == $past(ovfArmed_q))
    else $error("write to alternate byte moved latch or arm");

  a_alt_no_arm: assert property (@(posedge core_clk) disable iff (reset)
    (rdAltUp || rdAltLo) |=> ovfArmed_q == $past(ovfArmed_q))
    else $error("alternate read changed the clear sequence");

  a_main_apart: assert property (@(posedge core_clk) disable iff (reset)
    (rdMainUp || rdMainLo)
    |=> altFrozen_q == $past(altFrozen_q) && altLatch_q == $past(altLatch_q))
    else $error("main read touched alternate latch");

  a_reset_state: assert property (@(posedge core_clk)
    $fell(reset) |-> !altFrozen_q && !mainFrozen_q && !ovf_q)
    else $error("latches or flag not cleared by reset");

  a_unmapped_read: assert property (@(posedge core_clk) disable iff (reset)
    rdAcc && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  a_flag_hold: assert property (@(posedge core_clk) disable iff (reset)
    !wrapNow && !rdMainLo |=> ovf_q == $past(ovf_q))
    else $error("overflow flag moved without wrap or clear");

endmodule : acr_timer

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import acr_pkg::*;
;
  // ------------------------------------------------------------
  // stimulus, reference counter and score
  // ------------------------------------------------------------
  logic core_clk, reset, psel, penable, pwrite;
  logic [7:0] paddr, rnd;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, counterOverflowFlag, overflowIrq, e;
  logic [15:0] countValue, refCnt, c1, c2, c3; // bench's own count model
  logic [1:0] pre; // bench's own prescaler
  int mismatches, tests_run;
  acr_timer dut_u (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .countValue(countValue), .counterOverflowFlag(counterOverflowFlag),
    .overflowIrq(overflowIrq));
  // clock: 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // expected count, one step every four bus cycles
  always @(posedge core_clk) begin
    if (reset) begin
      refCnt <= COUNT_RESET;
      pre <= 2'h0;
    end else begin
      pre <= pre + 2'h1;
      if (pre == 2'h3) refCnt <= refCnt + 16'h0001;
    end
  end
  // next pseudo-random byte, taps give a long cycle
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ------------------------------------------------------------
  // apb master: setup, access held until pready at an edge
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err, output logic [15:0] cnt);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h1, 32'h0); // a stuck slave counts as a mismatch
    {rd, err, cnt} = {prdata, pslverr, refCnt}; // count seen at the take edge
    {psel, penable} <= 2'b00;
  endtask : apb
  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {mismatches, tests_run, rnd} = {32'h0, 32'h0, 8'h5e};
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk({16'h0, countValue}, 32'h0000fffc);
    apb(1'b0, ADDR_ALT_UPPER, 32'h0, r, e, c1);
    chk(r, 32'h000000ff);
    apb(1'b0, ADDR_ALT_LOWER, 32'h0, r, e, c2);
    chk(r, {24'h0, c1[7:0]});
    apb(1'b1, ADDR_CONTROL, 32'h20, r, e, c1);
    // wait past the early wrap, then the flag and request must stand
    for (int i = 0; i < 200 && refCnt != 16'h0003; i++) @(posedge core_clk);
    chk({30'h0, counterOverflowFlag, overflowIrq}, 32'h3);
    // latch sequences with random gaps and ignored writes
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, ADDR_ALT_UPPER, 32'h0, r, e, c1);
      chk(r, {24'h0, c1[15:8]});
      rnd = lfsr(rnd);
      repeat (rnd[3:0]) @(posedge core_clk);
      apb(1'b1, k[0] ? ADDR_ALT_UPPER : ADDR_ALT_LOWER, {4{rnd}}, r, e, c2);
      apb(1'b0, ADDR_ALT_UPPER, 32'h0, r, e, c2);
      chk(r, {24'h0, c2[15:8]});
      apb(1'b0, ADDR_ALT_LOWER, 32'h0, r, e, c2);
      chk(r, {24'h0, c1[7:0]});
      apb(1'b0, ADDR_ALT_LOWER, 32'h0, r, e, c2);
      chk(r, {24'h0, c2[7:0]});
      chk({16'h0, countValue}, {16'h0, refCnt});
      chk({31'h0, counterOverflowFlag}, 32'h1);
    end
    // interleaved main and alternate sequences
    apb(1'b0, ADDR_MAIN_UPPER, 32'h0, r, e, c1);
    chk(r, {24'h0, c1[15:8]});
    repeat (9) @(posedge core_clk);
    apb(1'b0, ADDR_ALT_UPPER, 32'h0, r, e, c2);
    apb(1'b0, ADDR_ALT_LOWER, 32'h0, r, e, c3);
    chk(r, {24'h0, c2[7:0]});
    apb(1'b0, ADDR_MAIN_LOWER, 32'h0, r, e, c2);
    chk(r, {24'h0, c1[7:0]});
    apb(1'b0, ADDR_MAIN_UPPER, 32'h0, r, e, c2);
    apb(1'b0, ADDR_MAIN_LOWER, 32'h0, r, e, c1);
    chk(r, {24'h0, c2[7:0]});
    chk({31'h0, counterOverflowFlag}, 32'h1);
    // status read then main lower read clears the flag
    apb(1'b0, ADDR_STATUS, 32'h0, r, e, c1);
    chk({31'h0, r[OVF_BIT]}, 32'h1);
    // an alternate lower read in the armed state must not clear
    apb(1'b0, ADDR_ALT_LOWER, 32'h0, r, e, c1);
    @(posedge core_clk);
    chk({30'h0, counterOverflowFlag, overflowIrq}, 32'h3);
    apb(1'b0, ADDR_MAIN_LOWER, 32'h0, r, e, c1);
    @(posedge core_clk);
    chk({30'h0, counterOverflowFlag, overflowIrq}, 32'h0);
    // unmapped address answers with an error and zero data
    apb(1'b0, 8'h18, 32'h0, r, e, c1);
    chk({e, r[30:0]}, 32'h80000000);
    end_of_test();
  end
endmodule : tb_top
